// File: rtl/txpsr_cal_sampler.sv
// comparator sampler driven by the software calibration strobe
`timescale 1ns/1ps
module txpsr_cal_sampler (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_manual,
	input wire logic i_strobe,
	input wire logic i_comp,
	output logic o_sample_pulse,
	output logic o_last_comp,
	output logic [3:0] o_count
);

	logic strobe_prev;
	logic next_strobe_prev;
	logic next_last_comp;
	logic [3:0] next_count;

	// falling strobe while manual counts as one sample
	assign o_sample_pulse = i_manual & strobe_prev & ~i_strobe;

	// next sample state
	always_comb begin
		next_strobe_prev = i_strobe;
		next_last_comp = o_last_comp;
		next_count = o_count;
		if (o_sample_pulse) begin
			next_last_comp = i_comp;
			next_count = o_count + 4'h1;
		end
	end

	// sample registers
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			strobe_prev <= 1'b0;
			o_last_comp <= 1'b0;
			o_count <= 4'h0;
		end else begin
			strobe_prev <= next_strobe_prev;
			o_last_comp <= next_last_comp;
			o_count <= next_count;
		end
	end

	// falling strobe in manual mode must capture the comparator level
	property p_strobe_sample;
		@(posedge i_core_clk) disable iff (i_srst)
		i_manual && $fell(i_strobe) |-> o_sample_pulse ##1
			o_last_comp == $past(i_comp);
	endproperty
	a_strobe_sample: assert property (p_strobe_sample)
		else $error("comparator not sampled on falling strobe");

endmodule : txpsr_cal_sampler

// File: rtl/txpsr_pkg.sv
// constants and types for the transmitter power and synthesizer override bank
package txpsr_pkg;

	// ------------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_STRENGTH = 8'h1C;
	localparam logic [7:0] IDX_SLEEP = 8'h20;
	localparam logic [7:0] IDX_FORCED_VALUES = 8'h21;
	localparam logic [7:0] IDX_LOOP_ARRAY = 8'h22;
	localparam logic [7:0] IDX_OSC_CAL = 8'h23;
	localparam logic [7:0] IDX_MODE = 8'h30;
	localparam logic [7:0] IDX_CAL_STATUS = 8'h31;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_STRENGTH = 8'h0F;
	localparam logic [7:0] RST_SLEEP = 8'h00;
	localparam logic [7:0] RST_FORCED_VALUES = 8'h4D;
	localparam logic [7:0] RST_LOOP_ARRAY = 8'h10;
	localparam logic [7:0] RST_OSC_CAL = 8'h06;
	localparam logic [7:0] RST_MODE = 8'h00;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int HIGH_MSB = 7;
	localparam int HIGH_LSB = 4;
	localparam int LOW_MSB = 3;
	localparam int LOW_LSB = 0;
	localparam int AMP_SLEEP_BIT = 7;
	localparam int OSC_SLEEP_BIT = 6;
	localparam int DIV_SLEEP_BIT = 5;
	localparam int PUMP_SLEEP_BIT = 4;
	localparam logic [7:0] SLEEP_WMASK = 8'hF0;
	localparam int DAC_MSB = 7;
	localparam int DAC_LSB = 4;
	localparam int PUMP_MSB = 3;
	localparam int PUMP_LSB = 0;
	localparam int LOOP_OPEN_BIT = 7;
	localparam int PUMP_FORCE_BIT = 6;
	localparam int ARRAY_FORCE_BIT = 5;
	localparam int ARRAY_MSB = 4;
	localparam int ARRAY_LSB = 0;
	localparam int MANUAL_BIT = 7;
	localparam int OSC_FORCE_BIT = 6;
	localparam int OSC_CUR_MSB = 5;
	localparam int OSC_CUR_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int MODE_LSB = 0;
	localparam logic [7:0] MODE_WMASK = 8'h03;
	localparam logic [1:0] SLEEP_MODE_BLOCKS = 2'h2;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] output_stage_strength;
		logic [7:0] block_sleep_control;
		logic [7:0] pump_and_dac_forced_values;
		logic [7:0] loop_and_array_force;
		logic [7:0] osc_current_cal_control;
		logic [7:0] sleep_mode_reg;
	} txpsr_regs_t;

	typedef struct packed {
		logic [3:0] cal_dac;
		logic [3:0] pump_current;
		logic [4:0] osc_array;
		logic [5:0] osc_current;
	} txpsr_cal_t;

	typedef struct packed {
		logic [3:0] high_array_strength;
		logic [3:0] low_array_strength;
		logic amp_sleep;
		logic osc_sleep;
		logic divider_buffer_sleep;
		logic pump_sleep;
		logic loop_open;
		logic manual_cal;
		logic osc_cal_strobe;
		logic [3:0] cal_dac;
		logic [3:0] pump_current;
		logic [4:0] osc_array;
		logic [5:0] osc_current;
	} txpsr_ctrl_t;

endpackage : txpsr_pkg

// File: rtl/txpsr_regs.sv
// power, sleep and synthesizer override register bank with apb access
`timescale 1ns/1ps
module txpsr_regs (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire txpsr_pkg::txpsr_cal_t i_cal,
	input wire logic i_cal_comp,
	output txpsr_pkg::txpsr_ctrl_t o_ctrl
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	txpsr_pkg::txpsr_regs_t regs;
	txpsr_pkg::txpsr_regs_t next_regs;
	txpsr_pkg::txpsr_ctrl_t next_ctrl;
	logic [31:0] next_prdata;
	logic [7:0] rd_byte;
	logic [7:0] idx;
	logic aligned;
	logic hit;
	logic setup;
	logic access;
	logic wr_en;
	logic sample_pulse;
	logic last_comp;
	logic [3:0] sample_count;
	logic manual;
	logic osc_force;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	assign idx = {2'h0, i_paddr[7:2]};
	assign aligned = (i_paddr[1:0] == 2'h0);
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;

	// known indices; anything else answers with an error
	always_comb begin
		hit = 1'b0;
		if (aligned) begin
			unique case (idx)
				txpsr_pkg::IDX_STRENGTH,
				txpsr_pkg::IDX_SLEEP,
				txpsr_pkg::IDX_FORCED_VALUES,
				txpsr_pkg::IDX_LOOP_ARRAY,
				txpsr_pkg::IDX_OSC_CAL,
				txpsr_pkg::IDX_MODE,
				txpsr_pkg::IDX_CAL_STATUS: begin
					hit = 1'b1;
				end
				default: hit = 1'b0;
			endcase
		end
	end

	// zero wait states: read data are loaded during the setup cycle
	assign o_pready = 1'b1;
	assign o_pslverr = access & ~hit;
	// only byte lane 0 carries register data
	assign wr_en = access & i_pwrite & hit & i_pstrb[0];

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	// write decode; status index is read only
	always_comb begin
		next_regs = regs;
		if (wr_en) begin
			unique case (idx)
				txpsr_pkg::IDX_STRENGTH: begin
					// both nibbles stored as written
					next_regs.output_stage_strength = i_pwdata[7:0];
				end
				txpsr_pkg::IDX_SLEEP: begin
					// reserved low bits never stored
					next_regs.block_sleep_control =
						i_pwdata[7:0] & txpsr_pkg::SLEEP_WMASK;
				end
				txpsr_pkg::IDX_FORCED_VALUES: begin
					next_regs.pump_and_dac_forced_values = i_pwdata[7:0];
				end
				txpsr_pkg::IDX_LOOP_ARRAY: begin
					next_regs.loop_and_array_force = i_pwdata[7:0];
				end
				txpsr_pkg::IDX_OSC_CAL: begin
					// force bit doubles as the strobe
					next_regs.osc_current_cal_control = i_pwdata[7:0];
				end
				txpsr_pkg::IDX_MODE: begin
					next_regs.sleep_mode_reg =
						i_pwdata[7:0] & txpsr_pkg::MODE_WMASK;
				end
				default: next_regs = regs;
			endcase
		end
	end

	// registers with their defaults
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			regs.output_stage_strength <= txpsr_pkg::RST_STRENGTH;
			regs.block_sleep_control <= txpsr_pkg::RST_SLEEP;
			regs.pump_and_dac_forced_values <=
				txpsr_pkg::RST_FORCED_VALUES;
			regs.loop_and_array_force <= txpsr_pkg::RST_LOOP_ARRAY;
			regs.osc_current_cal_control <= txpsr_pkg::RST_OSC_CAL;
			regs.sleep_mode_reg <= txpsr_pkg::RST_MODE;
		end else begin
			regs <= next_regs;
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	// byte for the addressed index, zero when unmapped
	always_comb begin
		rd_byte = 8'h00;
		if (aligned) begin
			unique case (idx)
				txpsr_pkg::IDX_STRENGTH: rd_byte = regs.output_stage_strength;
				txpsr_pkg::IDX_SLEEP: begin
					rd_byte = regs.block_sleep_control;
				end
				txpsr_pkg::IDX_FORCED_VALUES: begin
					rd_byte = regs.pump_and_dac_forced_values;
				end
				txpsr_pkg::IDX_LOOP_ARRAY: rd_byte = regs.loop_and_array_force;
				txpsr_pkg::IDX_OSC_CAL: rd_byte = regs.osc_current_cal_control;
				txpsr_pkg::IDX_MODE: rd_byte = regs.sleep_mode_reg;
				txpsr_pkg::IDX_CAL_STATUS: begin
					rd_byte = {sample_count, 3'h0, last_comp};
				end
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// capture in setup so prdata is a flop yet needs no wait state
	always_comb begin
		next_prdata = o_prdata;
		if (setup) begin
			next_prdata = {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_prdata <= 32'h00000000;
		end else begin
			o_prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------------
	// manual calibration strobe sampler
	// ------------------------------------------------------------------
	assign manual = regs.osc_current_cal_control[txpsr_pkg::MANUAL_BIT];
	assign osc_force = regs.osc_current_cal_control[txpsr_pkg::OSC_FORCE_BIT];

	txpsr_cal_sampler u_sampler (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_manual(manual),
		.i_strobe(osc_force),
		.i_comp(i_cal_comp),
		.o_sample_pulse(sample_pulse),
		.o_last_comp(last_comp),
		.o_count(sample_count)
	);

	// ------------------------------------------------------------------
	// analog control outputs
	// ------------------------------------------------------------------
	// one cycle behind the registers; analog settles far slower anyway
	always_comb begin
		next_ctrl.high_array_strength = regs.output_stage_strength
			[txpsr_pkg::HIGH_MSB:txpsr_pkg::HIGH_LSB];
		next_ctrl.low_array_strength = regs.output_stage_strength
			[txpsr_pkg::LOW_MSB:txpsr_pkg::LOW_LSB];
		next_ctrl.amp_sleep = (regs.sleep_mode_reg[1:0] ==
			txpsr_pkg::SLEEP_MODE_BLOCKS) &&
			regs.block_sleep_control[txpsr_pkg::AMP_SLEEP_BIT];
		next_ctrl.osc_sleep = (regs.sleep_mode_reg[1:0] ==
			txpsr_pkg::SLEEP_MODE_BLOCKS) &&
			regs.block_sleep_control[txpsr_pkg::OSC_SLEEP_BIT];
		next_ctrl.divider_buffer_sleep = (regs.sleep_mode_reg[1:0] ==
			txpsr_pkg::SLEEP_MODE_BLOCKS) &&
			regs.block_sleep_control[txpsr_pkg::DIV_SLEEP_BIT];
		next_ctrl.pump_sleep = (regs.sleep_mode_reg[1:0] ==
			txpsr_pkg::SLEEP_MODE_BLOCKS) &&
			regs.block_sleep_control[txpsr_pkg::PUMP_SLEEP_BIT];
		next_ctrl.loop_open =
			regs.loop_and_array_force[txpsr_pkg::LOOP_OPEN_BIT];
		next_ctrl.cal_dac = next_ctrl.loop_open ?
			regs.pump_and_dac_forced_values
			[txpsr_pkg::DAC_MSB:txpsr_pkg::DAC_LSB] :
			i_cal.cal_dac;
		next_ctrl.pump_current =
			regs.loop_and_array_force[txpsr_pkg::PUMP_FORCE_BIT] ?
			regs.pump_and_dac_forced_values
			[txpsr_pkg::PUMP_MSB:txpsr_pkg::PUMP_LSB] :
			i_cal.pump_current;
		next_ctrl.osc_array =
			regs.loop_and_array_force[txpsr_pkg::ARRAY_FORCE_BIT] ?
			regs.loop_and_array_force
			[txpsr_pkg::ARRAY_MSB:txpsr_pkg::ARRAY_LSB] :
			i_cal.osc_array;
		next_ctrl.manual_cal = manual;
		// in manual mode the force bit is a strobe, not a selector
		next_ctrl.osc_cal_strobe = manual & osc_force;
		next_ctrl.osc_current = (!manual && osc_force) ?
			regs.osc_current_cal_control
			[txpsr_pkg::OSC_CUR_MSB:txpsr_pkg::OSC_CUR_LSB] :
			i_cal.osc_current;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_ctrl <= '0;
		end else begin
			o_ctrl <= next_ctrl;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	property p_high_strength;
		wr_en && idx == txpsr_pkg::IDX_STRENGTH |=> ##1
			o_ctrl.high_array_strength == $past(i_pwdata[7:4], 2);
	endproperty
	a_high_strength: assert property (p_high_strength)
		else $error("high array strength not applied");

	property p_low_reset;
		$past(i_srst) |-> regs.output_stage_strength == 8'h0F &&
			regs.block_sleep_control == 8'h00 ##1
			o_ctrl.low_array_strength == 4'hF;
	endproperty
	a_low_reset: assert property (p_low_reset)
		else $error("strength defaults wrong after reset");

	property p_amp_sleep;
		o_ctrl.amp_sleep == $past(regs.block_sleep_control[7] &&
			regs.sleep_mode_reg[1:0] == 2'h2);
	endproperty
	a_amp_sleep: assert property (p_amp_sleep)
		else $error("amplifier sleep gating wrong");

	property p_osc_sleep;
		regs.sleep_mode_reg[1:0] != 2'h2 |=> !o_ctrl.osc_sleep;
	endproperty
	a_osc_sleep: assert property (p_osc_sleep)
		else $error("oscillator slept outside mode two");

	property p_div_sleep;
		regs.block_sleep_control[5] && regs.sleep_mode_reg[1:0] == 2'h2
			|=> o_ctrl.divider_buffer_sleep;
	endproperty
	a_div_sleep: assert property (p_div_sleep)
		else $error("divider sleep missing in mode two");

	property p_pump_sleep;
		o_ctrl.pump_sleep |-> $past(regs.block_sleep_control[4]);
	endproperty
	a_pump_sleep: assert property (p_pump_sleep)
		else $error("pump slept without its bit");

	property p_dac;
		o_ctrl.loop_open |-> o_ctrl.cal_dac ==
			$past(regs.pump_and_dac_forced_values[7:4]);
	endproperty
	a_dac: assert property (p_dac)
		else $error("forced dac not applied with loop open");

	property p_pump;
		!$past(i_srst) && $past(!regs.loop_and_array_force[6]) |->
			o_ctrl.pump_current == $past(i_cal.pump_current);
	endproperty
	a_pump: assert property (p_pump)
		else $error("calibrated pump current not used");

	property p_array;
		$past(regs.loop_and_array_force[5]) |->
			o_ctrl.osc_array == $past(regs.loop_and_array_force[4:0]);
	endproperty
	a_array: assert property (p_array)
		else $error("forced array value not used");

	property p_osc_current;
		$past(!manual && osc_force) |-> o_ctrl.osc_current ==
			$past(regs.osc_current_cal_control[5:0]);
	endproperty
	a_osc_current: assert property (p_osc_current)
		else $error("forced oscillator current not used");

	property p_manual_strobe;
		!manual |=> !o_ctrl.osc_cal_strobe && !o_ctrl.manual_cal;
	endproperty
	a_manual_strobe: assert property (p_manual_strobe)
		else $error("strobe active outside manual mode");

	property p_reserved_zero;
		setup && !i_pwrite && i_paddr == 8'h80 |=> o_prdata[3:0] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved sleep bits read nonzero");

	property p_readback;
		wr_en && idx == txpsr_pkg::IDX_LOOP_ARRAY |=>
			regs.loop_and_array_force == $past(i_pwdata[7:0]);
	endproperty
	a_readback: assert property (p_readback)
		else $error("written value not held");

	c_manual_sample: cover property (sample_pulse);
	c_mode_two_sleep: cover property (o_ctrl.amp_sleep);
	c_unmapped: cover property (o_pslverr);
	c_loop_open: cover property (o_ctrl.loop_open ##1 !o_ctrl.loop_open);

endmodule : txpsr_regs

// File: verification/txpsr_host.sv
// host-side apb master model that programs the register bank
`timescale 1ns/1ps
module txpsr_host (
	input wire logic i_core_clk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata,
	output logic [3:0] o_pstrb
);

	// ----------------------------------------------------------------
	// idle bus at time zero
	// ----------------------------------------------------------------
	initial begin
		o_psel = 1'h0;
		o_penable = 1'h0;
		o_pwrite = 1'h0;
		o_paddr = 8'h00;
		o_pwdata = 32'h00000000;
		o_pstrb = 4'h0;
	end

	// one transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic err);
		@(posedge i_core_clk);
		o_psel <= 1'h1;
		o_penable <= 1'h0;
		o_pwrite <= wr;
		o_paddr <= a;
		o_pwdata <= d;
		o_pstrb <= s;
		@(posedge i_core_clk);
		o_penable <= 1'h1;
		@(posedge i_core_clk);
		// no wait limit of its own; the bench timeout ends a hang
		while (i_pready !== 1'h1) begin
			@(posedge i_core_clk);
		end
		q = i_prdata;
		err = i_pslverr;
		o_psel <= 1'h0;
		o_penable <= 1'h0;
		// stale data would hide a slave that latches too late
		o_pwdata <= ~d;
	endtask : xfer

endmodule : txpsr_host

// File: verification/txpsr_regs_bench.sv
// self-checking bench for the power and synthesizer override bank
`timescale 1ns/1ps
module txpsr_regs_bench;

	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	txpsr_pkg::txpsr_cal_t cal = {4'h3, 4'h7, 5'h0B, 6'h21};
	logic comp = 1'h0;
	txpsr_pkg::txpsr_ctrl_t ctrl;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] vals [4] = '{8'hA5, 8'h00, 8'hF1, 8'h0A};
	logic [7:0] ovr [5] = '{8'h00, 8'h80, 8'h40, 8'h23, 8'hE5};

	always #2.5 clk = ~clk;

	txpsr_host u_host (.i_core_clk(clk), .i_pready(pready),
		.i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata), .o_pstrb(pstrb));

	txpsr_regs u_dut (.i_core_clk(clk), .i_srst(srst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_cal(cal),
		.i_cal_comp(comp), .o_ctrl(ctrl));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] addr(input logic [7:0] idx);
		return {idx[5:0], 2'h0};
	endfunction : addr

	task automatic summarize;
		$display("counts: compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h",
				$time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		u_host.xfer(1'h1, addr(idx), {24'h000000, d}, 4'hF, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
		input string what);
		logic [31:0] q;
		logic e;
		u_host.xfer(1'h0, addr(idx), 32'h00000000, 4'h0, q, e);
		chk(q, {24'h000000, exp}, what);
	endtask : rd

	// control outputs trail the register by one edge
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			$display("MISMATCH t=%0t run did not finish", $time);
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		settle();
		chk(ctrl.low_array_strength, 4'hF, "low reset");
		chk(ctrl.high_array_strength, 4'h0, "high reset");
		chk(ctrl.cal_dac, cal.cal_dac, "dac loop closed");
		chk(ctrl.osc_array, cal.osc_array, "array cal");
		rd(txpsr_pkg::IDX_STRENGTH, 8'h0F, "strength rst");
		rd(txpsr_pkg::IDX_SLEEP, 8'h00, "sleep rst");
		rd(txpsr_pkg::IDX_FORCED_VALUES, 8'h4D, "forced rst");
		rd(txpsr_pkg::IDX_LOOP_ARRAY, 8'h10, "loop rst");
		rd(txpsr_pkg::IDX_OSC_CAL, 8'h06, "osc rst");
		$display("test defaults done");
		// last entry drives one nibble only, the lean setting
		foreach (vals[i]) begin
			wr(txpsr_pkg::IDX_STRENGTH, vals[i]);
			settle();
			chk(ctrl.high_array_strength, vals[i][7:4], "high");
			chk(ctrl.low_array_strength, vals[i][3:0], "low");
			rd(txpsr_pkg::IDX_STRENGTH, vals[i], "strength rb");
		end
		u_host.xfer(1'h1, addr(txpsr_pkg::IDX_STRENGTH), 32'h55, 4'hE, q, e);
		rd(txpsr_pkg::IDX_STRENGTH, 8'h0A, "no strobe");
		$display("test strength done");
		wr(txpsr_pkg::IDX_SLEEP, 8'hFF);
		rd(txpsr_pkg::IDX_SLEEP, 8'hF0, "reserved");
		for (int m = 0; m < 4; m++) begin
			wr(txpsr_pkg::IDX_MODE, m[7:0]);
			settle();
			chk({ctrl.amp_sleep, ctrl.osc_sleep, ctrl.divider_buffer_sleep,
				ctrl.pump_sleep}, (m == 2) ? 4'hF : 4'h0,
				"mode gate");
		end
		wr(txpsr_pkg::IDX_MODE, 8'h02);
		for (int k = 0; k < 4; k++) begin
			wr(txpsr_pkg::IDX_SLEEP, 8'h80 >> k);
			settle();
			chk({ctrl.amp_sleep, ctrl.osc_sleep, ctrl.divider_buffer_sleep,
				ctrl.pump_sleep}, 4'h8 >> k,
				"sleep bit");
		end
		$display("test sleep done");
		wr(txpsr_pkg::IDX_FORCED_VALUES, 8'h9C);
		foreach (ovr[i]) begin
			wr(txpsr_pkg::IDX_LOOP_ARRAY, ovr[i]);
			settle();
			chk(ctrl.loop_open, ovr[i][7], "loop open");
			chk(ctrl.cal_dac, ovr[i][7] ? 4'h9 : cal.cal_dac, "dac");
			chk(ctrl.pump_current, ovr[i][6] ? 4'hC : cal.pump_current,
				"pump");
			chk(ctrl.osc_array, ovr[i][5] ? ovr[i][4:0] : cal.osc_array,
				"array");
		end
		$display("test overrides done");
		wr(txpsr_pkg::IDX_OSC_CAL, 8'h4A);
		settle();
		chk(ctrl.osc_current, 6'h0A, "osc forced");
		chk(ctrl.osc_cal_strobe, 1'h0, "no strobe off");
		wr(txpsr_pkg::IDX_OSC_CAL, 8'h0A);
		settle();
		chk(ctrl.osc_current, cal.osc_current, "osc cal");
		@(posedge clk);
		comp <= 1'h1;
		wr(txpsr_pkg::IDX_OSC_CAL, 8'hC0);
		settle();
		chk(ctrl.manual_cal, 1'h1, "manual on");
		chk(ctrl.osc_cal_strobe, 1'h1, "strobe high");
		chk(ctrl.osc_current, cal.osc_current, "osc manual");
		wr(txpsr_pkg::IDX_OSC_CAL, 8'h80);
		rd(txpsr_pkg::IDX_CAL_STATUS, 8'h11, "first sample");
		comp <= 1'h0;
		wr(txpsr_pkg::IDX_OSC_CAL, 8'hC0);
		wr(txpsr_pkg::IDX_OSC_CAL, 8'h80);
		rd(txpsr_pkg::IDX_CAL_STATUS, 8'h20, "second sample");
		wr(txpsr_pkg::IDX_CAL_STATUS, 8'hFF);
		rd(txpsr_pkg::IDX_CAL_STATUS, 8'h20, "status ro");
		$display("test manual calibration done");
		u_host.xfer(1'h0, 8'h04, 32'h0, 4'h0, q, e);
		chk(e, 1'h1, "unmapped err");
		chk(q, 32'h0, "unmapped data");
		u_host.xfer(1'h1, 8'h71, 32'h0, 4'hF, q, e);
		chk(e, 1'h1, "misaligned err");
		rd(txpsr_pkg::IDX_STRENGTH, 8'h0A, "write dropped");
		$display("test unmapped done");
		srst <= 1'h1;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		settle();
		chk(ctrl.low_array_strength, 4'hF, "low after rst");
		chk(ctrl.manual_cal, 1'h0, "manual after rst");
		rd(txpsr_pkg::IDX_STRENGTH, 8'h0F, "strength rst2");
		rd(txpsr_pkg::IDX_OSC_CAL, 8'h06, "osc rst2");
		rd(txpsr_pkg::IDX_SLEEP, 8'h00, "sleep rst2");
		rd(txpsr_pkg::IDX_MODE, 8'h00, "mode rst2");
		rd(txpsr_pkg::IDX_CAL_STATUS, 8'h00, "status rst2");
		$display("test second reset done");
		summarize();
	end

endmodule : txpsr_regs_bench
